// ==== verilog/core_pkg.sv ====
// constants and types shared by the instruction timing and arithmetic core
// assumes one clock domain, synchronous active-low reset, no register bus
// Behaviour
// - one instruction cycle is four clocks
// - most one cycle; branch, call, return, table two
// - write to pointer low byte jumps, extra cycle
// - skip taken costs one extra cycle
// - add/subtract update zero, carry, half, wrap flags
// - memory-destination add/subtract write memory, same flags
// - carry above 255, borrow below zero
// - bcd fixup to memory, carry only
// - and/or/xor affect zero flag only
// - invert byte, zero flag, acc or memory
// - increment/decrement by one, zero flag only
// - rotate one bit; through forms use carry
// - bit set/clear touches only bit 0..7
// - three move forms supported
// - conditional test then execute or skip next
// - call saves return point; goto saves none
// - table read copies program memory into data memory
package core_pkg;
	localparam int CLKS_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_FETCH = 2'h0;
	localparam logic [1:0] PHASE_READ = 2'h2;
	localparam logic [1:0] PHASE_EXEC = 2'(CLKS_PER_CYCLE - 1);
	localparam logic [7:0] PROGRAM_POINTER_LOW_ADDR = 8'h06;
	localparam logic [11:0] RESET_PC = 12'h000;
	localparam int STACK_DEPTH = 8;
	localparam logic [2:0] PFX_GOTO = 3'h6;
	localparam logic [2:0] PFX_CALL = 3'h7;
	localparam logic [3:0] PFX_SKIP_BIT_ZERO = 4'h8;
	localparam logic [3:0] PFX_SKIP_BIT_SET = 4'h9;
	localparam logic [3:0] PFX_BIT_SET = 4'hA;
	localparam logic [3:0] PFX_BIT_CLEAR = 4'hB;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [8:0] BCD_LOW_FIX = 9'h006;
	localparam logic [8:0] BCD_HIGH_FIX = 9'h060;
	localparam logic [7:0] RESET_WORKING = 8'h00;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_STALL = 2'b01,
		ST_TABLE = 2'b11
	} state_type;

	typedef enum logic [5:0] {
		OP_NOP, OP_ADD_MEM, OP_ADD_TO_MEM, OP_ADD_IMM, OP_ADDC_MEM, OP_ADDC_TO_MEM,
		OP_SUB_IMM, OP_SUB_MEM, OP_SUB_TO_MEM, OP_SUBC_MEM, OP_SUBC_TO_MEM,
		OP_BCD_FIXUP, OP_AND_MEM, OP_OR_MEM, OP_XOR_MEM, OP_AND_TO_MEM,
		OP_OR_TO_MEM, OP_XOR_TO_MEM, OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM,
		OP_INVERT_TO_MEM, OP_INVERT, OP_INC, OP_INC_TO_MEM, OP_DEC, OP_DEC_TO_MEM,
		OP_ROR, OP_ROR_TO_MEM, OP_ROR_THRU, OP_ROR_THRU_TO_MEM, OP_ROL,
		OP_ROL_TO_MEM, OP_ROL_THRU, OP_ROL_THRU_TO_MEM, OP_LOAD_MEM, OP_STORE_MEM,
		OP_LOAD_IMM, OP_SKIP_ZERO, OP_SKIP_ZERO_LOAD, OP_SKIP_INC, OP_SKIP_DEC,
		OP_SKIP_INC_LOAD, OP_SKIP_DEC_LOAD, OP_LEAVE, OP_LEAVE_IMM, OP_TABLE_READ,
		OP_CLEAR_MEM, OP_FILL_MEM, OP_SWAP_TO_MEM, OP_SWAP
	} op_type;
endpackage

// ==== verilog/instruction_timing_alu_core.sv ====
// instruction sequencer and alu of an 8-bit single working register core
// assumes program and data memories answer within the clock after the address
`timescale 1ns/1ps
module instruction_timing_alu_core (
	input wire logic clk_in,
	input wire logic nrst_in,
	output logic [11:0] pmem_addr_out,
	input wire logic [14:0] pmem_data_in,
	output logic [7:0] dmem_addr_out,
	input wire logic [7:0] dmem_rdata_in,
	output logic [7:0] dmem_wdata_out,
	output logic dmem_we_out,
	output logic [7:0] working_register_out,
	output logic zero_flag_out,
	output logic carry_flag_out,
	output logic half_nibble_flag_out,
	output logic signed_wrap_flag_out,
	output logic [6:0] table_high_out,
	output logic [11:0] program_pointer_out,
	output logic instr_done_out
);
	localparam int SPW = $clog2(core_pkg::STACK_DEPTH);

	core_pkg::state_type state_q;
	logic [1:0] phase_q;
	logic [14:0] ir_q;
	logic [7:0] mdata_q;
	logic [14:0] tdata_q;
	logic [11:0] pc_q;
	logic [11:0] pmem_addr_q;
	logic [7:0] dmem_addr_q;
	logic [7:0] wdata_q;
	logic we_q;
	logic [7:0] working_register_q;
	logic zero_q;
	logic carry_q;
	logic half_nibble_flag_q;
	logic signed_wrap_flag_q;
	logic [6:0] table_high_q;
	logic [11:0] stack_q [core_pkg::STACK_DEPTH];
	logic [SPW-1:0] sp_q;

	core_pkg::op_type op;
	logic [7:0] opnd;
	logic [2:0] bit_sel;
	logic [7:0] res;
	logic has_res;
	logic mem_form;
	logic to_acc;
	logic to_mem;
	logic arith;
	logic is_sub;
	logic use_carry;
	logic upd_z;
	logic upd_c;
	logic upd_hw;
	logic c_n;
	logic hn_n;
	logic sw_n;
	logic skip;
	logic jump;
	logic push;
	logic pop;
	logic tbl;
	logic pcl_write;
	logic stall;
	logic [8:0] bcd_lo;
	logic [8:0] bcd_hi;
	logic exec;
	logic [11:0] pc_next;

	// adder returns {carry, half carry, signed overflow, sum}
	function automatic logic [10:0] add8(input logic [7:0] x, input logic [7:0] y, input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
		h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
		add8 = {s[8], h[4], (x[7] == y[7]) && (s[7] != x[7]), s[7:0]};
	endfunction

	assign op = core_pkg::op_type'(ir_q[13:8]);
	assign bit_sel = ir_q[10:8];
	assign opnd = (op inside {core_pkg::OP_ADD_IMM, core_pkg::OP_SUB_IMM, core_pkg::OP_AND_IMM,
		core_pkg::OP_OR_IMM, core_pkg::OP_XOR_IMM, core_pkg::OP_LOAD_IMM}) ? ir_q[7:0] : mdata_q;
	assign exec = (state_q == core_pkg::ST_RUN) && (phase_q == core_pkg::PHASE_EXEC);

	always_comb begin
		res = 8'h00;
		has_res = 1'b0;
		mem_form = 1'b0;
		arith = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		upd_hw = 1'b0;
		c_n = carry_q;
		hn_n = half_nibble_flag_q;
		sw_n = signed_wrap_flag_q;
		skip = 1'b0;
		jump = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		tbl = 1'b0;
		bcd_lo = 9'h000;
		bcd_hi = 9'h000;
		is_sub = op inside {core_pkg::OP_SUB_IMM, core_pkg::OP_SUB_MEM, core_pkg::OP_SUB_TO_MEM,
			core_pkg::OP_SUBC_MEM, core_pkg::OP_SUBC_TO_MEM};
		use_carry = op inside {core_pkg::OP_ADDC_MEM, core_pkg::OP_ADDC_TO_MEM,
			core_pkg::OP_SUBC_MEM, core_pkg::OP_SUBC_TO_MEM};
		if (ir_q[14:12] == core_pkg::PFX_GOTO) begin
			jump = 1'b1;
		end else if (ir_q[14:12] == core_pkg::PFX_CALL) begin
			jump = 1'b1;
			push = 1'b1;
		end else if (ir_q[14]) begin
			res = mdata_q;
			case (ir_q[14:11])
				core_pkg::PFX_SKIP_BIT_ZERO: skip = ~mdata_q[bit_sel];
				core_pkg::PFX_SKIP_BIT_SET: skip = mdata_q[bit_sel];
				core_pkg::PFX_BIT_SET: begin
					res[bit_sel] = 1'b1;
					has_res = 1'b1;
					mem_form = 1'b1;
				end
				default: begin
					res[bit_sel] = 1'b0;
					has_res = 1'b1;
					mem_form = 1'b1;
				end
			endcase
		end else begin
			mem_form = op inside {core_pkg::OP_ADD_TO_MEM, core_pkg::OP_ADDC_TO_MEM,
				core_pkg::OP_SUB_TO_MEM, core_pkg::OP_SUBC_TO_MEM, core_pkg::OP_BCD_FIXUP,
				core_pkg::OP_AND_TO_MEM, core_pkg::OP_OR_TO_MEM, core_pkg::OP_XOR_TO_MEM,
				core_pkg::OP_INVERT_TO_MEM, core_pkg::OP_INC_TO_MEM, core_pkg::OP_DEC_TO_MEM,
				core_pkg::OP_ROR_TO_MEM, core_pkg::OP_ROR_THRU_TO_MEM, core_pkg::OP_ROL_TO_MEM,
				core_pkg::OP_ROL_THRU_TO_MEM, core_pkg::OP_STORE_MEM, core_pkg::OP_SKIP_INC,
				core_pkg::OP_SKIP_DEC, core_pkg::OP_CLEAR_MEM, core_pkg::OP_FILL_MEM,
				core_pkg::OP_SWAP_TO_MEM};
			has_res = 1'b1;
			case (op)
				core_pkg::OP_ADD_MEM, core_pkg::OP_ADD_TO_MEM, core_pkg::OP_ADD_IMM,
				core_pkg::OP_ADDC_MEM, core_pkg::OP_ADDC_TO_MEM, core_pkg::OP_SUB_IMM,
				core_pkg::OP_SUB_MEM, core_pkg::OP_SUB_TO_MEM, core_pkg::OP_SUBC_MEM,
				core_pkg::OP_SUBC_TO_MEM: arith = 1'b1;
				core_pkg::OP_BCD_FIXUP: begin
					bcd_lo = {1'b0, working_register_q};
					if ((working_register_q[3:0] > core_pkg::BCD_DIGIT_MAX) || half_nibble_flag_q)
						bcd_lo = bcd_lo + core_pkg::BCD_LOW_FIX;
					bcd_hi = {1'b0, bcd_lo[7:0]};
					if ((bcd_lo[7:4] > core_pkg::BCD_DIGIT_MAX) || carry_q || bcd_lo[8])
						bcd_hi = bcd_hi + core_pkg::BCD_HIGH_FIX;
					res = bcd_hi[7:0];
					c_n = carry_q | bcd_lo[8] | bcd_hi[8];
					upd_c = 1'b1;
				end
				core_pkg::OP_AND_MEM, core_pkg::OP_AND_TO_MEM, core_pkg::OP_AND_IMM: begin
					res = working_register_q & opnd;
					upd_z = 1'b1;
				end
				core_pkg::OP_OR_MEM, core_pkg::OP_OR_TO_MEM, core_pkg::OP_OR_IMM: begin
					res = working_register_q | opnd;
					upd_z = 1'b1;
				end
				core_pkg::OP_XOR_MEM, core_pkg::OP_XOR_TO_MEM, core_pkg::OP_XOR_IMM: begin
					res = working_register_q ^ opnd;
					upd_z = 1'b1;
				end
				core_pkg::OP_INVERT, core_pkg::OP_INVERT_TO_MEM: begin
					res = ~mdata_q;
					upd_z = 1'b1;
				end
				core_pkg::OP_INC, core_pkg::OP_INC_TO_MEM: begin
					res = mdata_q + 8'h01;
					upd_z = 1'b1;
				end
				core_pkg::OP_DEC, core_pkg::OP_DEC_TO_MEM: begin
					res = mdata_q - 8'h01;
					upd_z = 1'b1;
				end
				core_pkg::OP_ROR, core_pkg::OP_ROR_TO_MEM: res = {mdata_q[0], mdata_q[7:1]};
				core_pkg::OP_ROL, core_pkg::OP_ROL_TO_MEM: res = {mdata_q[6:0], mdata_q[7]};
				core_pkg::OP_ROR_THRU, core_pkg::OP_ROR_THRU_TO_MEM: begin
					res = {carry_q, mdata_q[7:1]};
					c_n = mdata_q[0];
					upd_c = 1'b1;
				end
				core_pkg::OP_ROL_THRU, core_pkg::OP_ROL_THRU_TO_MEM: begin
					res = {mdata_q[6:0], carry_q};
					c_n = mdata_q[7];
					upd_c = 1'b1;
				end
				core_pkg::OP_LOAD_MEM, core_pkg::OP_LOAD_IMM: res = opnd;
				core_pkg::OP_STORE_MEM: res = working_register_q;
				core_pkg::OP_SKIP_ZERO: begin
					has_res = 1'b0;
					skip = (mdata_q == 8'h00);
				end
				core_pkg::OP_SKIP_ZERO_LOAD: begin
					res = mdata_q;
					skip = (mdata_q == 8'h00);
				end
				core_pkg::OP_SKIP_INC, core_pkg::OP_SKIP_INC_LOAD: begin
					res = mdata_q + 8'h01;
					skip = (res == 8'h00);
				end
				core_pkg::OP_SKIP_DEC, core_pkg::OP_SKIP_DEC_LOAD: begin
					res = mdata_q - 8'h01;
					skip = (res == 8'h00);
				end
				core_pkg::OP_LEAVE: begin
					has_res = 1'b0;
					pop = 1'b1;
				end
				core_pkg::OP_LEAVE_IMM: begin
					res = ir_q[7:0];
					pop = 1'b1;
				end
				core_pkg::OP_TABLE_READ: begin
					has_res = 1'b0;
					tbl = 1'b1;
				end
				core_pkg::OP_CLEAR_MEM: res = 8'h00;
				core_pkg::OP_FILL_MEM: res = 8'hFF;
				core_pkg::OP_SWAP, core_pkg::OP_SWAP_TO_MEM: res = {mdata_q[3:0], mdata_q[7:4]};
				default: has_res = 1'b0;
			endcase
			if (arith) begin
				// subtract is x + ~y + 1, so carry out means no borrow
				{c_n, hn_n, sw_n, res} = add8(working_register_q, is_sub ? ~opnd : opnd,
					use_carry ? carry_q : is_sub);
				upd_z = 1'b1;
				upd_c = 1'b1;
				upd_hw = 1'b1;
			end
		end
		to_acc = has_res & ~mem_form;
		to_mem = has_res & mem_form;
	end

	assign pcl_write = to_mem && (dmem_addr_q == core_pkg::PROGRAM_POINTER_LOW_ADDR);
	assign stall = jump | skip | push | pop | tbl | pcl_write;

	always_comb begin
		pc_next = pc_q + 12'h001;
		if (jump)
			pc_next = ir_q[11:0];
		else if (pop)
			pc_next = stack_q[sp_q - SPW'(1)];
		else if (pcl_write)
			pc_next = {pc_q[11:8], res};
		else if (skip)
			pc_next = pc_q + 12'h002;
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in)
			phase_q <= core_pkg::PHASE_FETCH;
		else
			phase_q <= phase_q + 2'h1;
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			state_q <= core_pkg::ST_RUN;
		end else if (phase_q == core_pkg::PHASE_EXEC) begin
			case (state_q)
				core_pkg::ST_RUN: begin
					if (tbl)
						state_q <= core_pkg::ST_TABLE;
					else if (stall)
						state_q <= core_pkg::ST_STALL;
				end
				default: state_q <= core_pkg::ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ir_q <= 15'h0000;
			tdata_q <= 15'h0000;
			dmem_addr_q <= 8'h00;
			mdata_q <= 8'h00;
		end else begin
			if (phase_q == core_pkg::PHASE_FETCH && state_q == core_pkg::ST_RUN) begin
				ir_q <= pmem_data_in;
				dmem_addr_q <= pmem_data_in[7:0];
			end
			if (phase_q == core_pkg::PHASE_FETCH && state_q == core_pkg::ST_TABLE)
				tdata_q <= pmem_data_in;
			// the pointer low byte lives here, not in data memory
			if (phase_q == core_pkg::PHASE_READ && state_q == core_pkg::ST_RUN)
				mdata_q <= (dmem_addr_q == core_pkg::PROGRAM_POINTER_LOW_ADDR) ? pc_q[7:0]
					: dmem_rdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pc_q <= core_pkg::RESET_PC;
			pmem_addr_q <= core_pkg::RESET_PC;
			sp_q <= '0;
		end else if (exec) begin
			pc_q <= pc_next;
			pmem_addr_q <= tbl ? {pc_q[11:8], working_register_q} : pc_next;
			if (push) begin
				stack_q[sp_q] <= pc_q + 12'h001;
				sp_q <= sp_q + SPW'(1);
			end else if (pop) begin
				sp_q <= sp_q - SPW'(1);
			end
		end else if (state_q == core_pkg::ST_TABLE && phase_q == core_pkg::PHASE_EXEC) begin
			pmem_addr_q <= pc_q;
		end
	end

	// writes strobe during the fetch clock of the next cycle, address still held
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			we_q <= 1'b0;
			wdata_q <= 8'h00;
			table_high_q <= 7'h00;
		end else if (exec) begin
			we_q <= to_mem && !pcl_write;
			wdata_q <= res;
		end else if (state_q == core_pkg::ST_TABLE && phase_q == core_pkg::PHASE_EXEC) begin
			we_q <= 1'b1;
			wdata_q <= tdata_q[7:0];
			table_high_q <= tdata_q[14:8];
		end else begin
			we_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			working_register_q <= core_pkg::RESET_WORKING;
			zero_q <= 1'b0;
			carry_q <= 1'b0;
			half_nibble_flag_q <= 1'b0;
			signed_wrap_flag_q <= 1'b0;
		end else if (exec) begin
			if (to_acc)
				working_register_q <= res;
			if (upd_z)
				zero_q <= (res == 8'h00);
			if (upd_c)
				carry_q <= c_n;
			if (upd_hw) begin
				half_nibble_flag_q <= hn_n;
				signed_wrap_flag_q <= sw_n;
			end
		end
	end

	assign pmem_addr_out = pmem_addr_q;
	assign dmem_addr_out = dmem_addr_q;
	assign dmem_wdata_out = wdata_q;
	assign dmem_we_out = we_q;
	assign working_register_out = working_register_q;
	assign zero_flag_out = zero_q;
	assign carry_flag_out = carry_q;
	assign half_nibble_flag_out = half_nibble_flag_q;
	assign signed_wrap_flag_out = signed_wrap_flag_q;
	assign table_high_out = table_high_q;
	assign program_pointer_out = pc_q;
	assign instr_done_out = (phase_q == core_pkg::PHASE_EXEC) && !(exec && stall);
endmodule

// ==== testbench/core_mem_model.sv ====
// program and data memory standing beside the core
// assumes the bench fills both arrays before reset is released
`timescale 1ns/1ps
module core_mem_model (
	input wire logic clk_in,
	input wire logic [11:0] pmem_addr_in,
	output logic [14:0] pmem_data_out,
	input wire logic [7:0] dmem_addr_in,
	output logic [7:0] dmem_rdata_out,
	input wire logic [7:0] dmem_wdata_in,
	input wire logic dmem_we_in
);
	logic [14:0] pmem [4096];
	logic [7:0] dmem [256];
	// table words share the code array, as the core reads them with the same port
	assign pmem_data_out = pmem[pmem_addr_in];
	assign dmem_rdata_out = dmem[dmem_addr_in];
	always @(posedge clk_in) begin
		if (dmem_we_in === 1'b1)
			dmem[dmem_addr_in] <= dmem_wdata_in;
	end
endmodule

// ==== testbench/instruction_timing_alu_core_sva.sv ====
// assertions on the core's ports: cycle counts, branches, bit writes
// assumes the four-clock phase restarts at zero on reset release
`timescale 1ns/1ps
module instruction_timing_alu_core_sva (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [11:0] pmem_addr_out,
	input wire logic [14:0] pmem_data_in,
	input wire logic [7:0] dmem_addr_out,
	input wire logic [7:0] dmem_rdata_in,
	input wire logic [7:0] dmem_wdata_out,
	input wire logic dmem_we_out,
	input wire logic [7:0] working_register_out,
	input wire logic zero_flag_out,
	input wire logic carry_flag_out,
	input wire logic instr_done_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	logic [1:0] ph_q;
	logic fetch_q;
	logic [3:0] idle_q;
	wire logic fetch = fetch_q && ph_q == 2'h0;
	wire logic ptr = pmem_data_in[7:0] == core_pkg::PROGRAM_POINTER_LOW_ADDR;
	wire logic alu = fetch && !pmem_data_in[14] && !ptr;
	wire logic [5:0] op = pmem_data_in[13:8];
	wire logic [3:0] pfx = pmem_data_in[14:11];
	// a word is taken only in the phase 0 that follows a completed instruction
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ph_q <= 2'h0;
			fetch_q <= 1'b1;
			idle_q <= 4'h0;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (ph_q == 2'h3)
				fetch_q <= instr_done_out;
			idle_q <= instr_done_out ? 4'h0 : idle_q + 4'h1;
		end
	end
	AST_CYCLE_LEN: assert property (instr_done_out |=> !instr_done_out [*3])
		else $error("done pulses closer than four clocks");
	AST_NO_HANG: assert property (idle_q < 4'h8)
		else $error("instruction longer than two machine cycles");
	AST_ONE_CYCLE: assert property (alu && op inside {[6'h01:6'h1A]} |-> ##3 instr_done_out)
		else $error("data operation not done in one machine cycle");
	AST_BRANCH: assert property (fetch && pmem_data_in[14:13] == 2'h3 |-> ##3 !instr_done_out ##4
		instr_done_out ##1 pmem_addr_out == $past(pmem_data_in[11:0], 8))
		else $error("branch target or length wrong");
	AST_LEAVE: assert property (alu && op == 6'(core_pkg::OP_LEAVE) |-> ##7 instr_done_out)
		else $error("return not two machine cycles");
	AST_PTR_JUMP: assert property (fetch && !pmem_data_in[14] && ptr
		&& op == 6'(core_pkg::OP_STORE_MEM) |-> ##4 !dmem_we_out ##3 instr_done_out
		##1 pmem_addr_out[7:0] == $past(working_register_out, 8))
		else $error("pointer low write did not jump");
	AST_NO_PTR_WRITE: assert property (dmem_we_out |-> !(dmem_addr_out == 8'h06))
		else $error("pointer low byte reached data memory");
	AST_SKIP: assert property (alu && op == 6'(core_pkg::OP_SKIP_ZERO) |-> ##2
		((dmem_rdata_in == 8'h00 ##5 instr_done_out) or (dmem_rdata_in != 8'h00 ##1 instr_done_out)))
		else $error("skip timing wrong");
	AST_BIT_SET: assert property (fetch && !ptr && pfx == core_pkg::PFX_BIT_SET |-> ##4
		dmem_we_out && dmem_wdata_out == ($past(dmem_rdata_in, 2) | (8'h01 << $past(pmem_data_in[10:8], 4))))
		else $error("bit set wrote wrong byte");
	AST_BIT_CLEAR: assert property (fetch && !ptr && pfx == core_pkg::PFX_BIT_CLEAR |-> ##4
		dmem_we_out && dmem_wdata_out == ($past(dmem_rdata_in, 2) & ~(8'h01 << $past(pmem_data_in[10:8], 4))))
		else $error("bit clear wrote wrong byte");
	AST_LOAD_IMM: assert property (alu && op == 6'(core_pkg::OP_LOAD_IMM) |-> ##4
		working_register_out == $past(pmem_data_in[7:0], 4) && $stable({zero_flag_out, carry_flag_out}))
		else $error("immediate move wrong or touched flags");
	cover property (fetch && pmem_data_in[14:12] == core_pkg::PFX_CALL);
	cover property (alu && op == 6'(core_pkg::OP_SKIP_ZERO) ##2 dmem_rdata_in == 8'h00);
	cover property (alu && op == 6'(core_pkg::OP_TABLE_READ));
endmodule
bind instruction_timing_alu_core instruction_timing_alu_core_sva i_instruction_timing_alu_core_sva (
	.clk_in, .nrst_in, .pmem_addr_out, .pmem_data_in, .dmem_addr_out, .dmem_rdata_in,
	.dmem_wdata_out, .dmem_we_out, .working_register_out, .zero_flag_out, .carry_flag_out,
	.instr_done_out);

// ==== testbench/instruction_timing_alu_core_bench.sv ====
// self-checking bench: builds a program, predicts each instruction's outcome
// assumes the memory model answers combinationally
`timescale 1ns/1ps
module instruction_timing_alu_core_bench;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [11:0] pmem_addr_out;
	logic [14:0] pmem_data_in, tw;
	logic [7:0] dmem_addr_out, dmem_rdata_in, dmem_wdata_out, working_register_out, acc;
	logic dmem_we_out, zero_flag_out, carry_flag_out, half_nibble_flag_out, signed_wrap_flag_out;
	logic instr_done_out;
	logic [6:0] table_high_out;
	logic [11:0] pc, ret, program_pointer_out;
	logic [23:0] nx;
	logic [3:0] fl;
	logic [7:0] dm [256];
	logic [23:0] done_q[$];
	logic [15:0] wr_q[$];
	int err_total = 0;
	int checked = 0;
	int seed = 32'h4509;
	core_pkg::op_type ops [17] = '{core_pkg::OP_ADDC_MEM, core_pkg::OP_ADD_TO_MEM,
		core_pkg::OP_SUB_MEM, core_pkg::OP_SUBC_TO_MEM, core_pkg::OP_AND_IMM, core_pkg::OP_OR_MEM,
		core_pkg::OP_XOR_TO_MEM, core_pkg::OP_INVERT, core_pkg::OP_INC_TO_MEM, core_pkg::OP_DEC,
		core_pkg::OP_LOAD_MEM, core_pkg::OP_STORE_MEM, core_pkg::OP_LOAD_IMM, core_pkg::OP_ROR,
		core_pkg::OP_ROL_TO_MEM, core_pkg::OP_ROR_THRU, core_pkg::OP_ROL_THRU_TO_MEM};
	always #5 clk_in = ~clk_in;
	instruction_timing_alu_core i_instruction_timing_alu_core (.clk_in, .nrst_in, .pmem_addr_out,
		.pmem_data_in, .dmem_addr_out, .dmem_rdata_in, .dmem_wdata_out, .dmem_we_out,
		.working_register_out, .zero_flag_out, .carry_flag_out, .half_nibble_flag_out,
		.signed_wrap_flag_out, .table_high_out, .program_pointer_out, .instr_done_out);
	core_mem_model i_core_mem_model (.clk_in, .pmem_addr_in(pmem_addr_out),
		.pmem_data_out(pmem_data_in), .dmem_addr_in(dmem_addr_out), .dmem_rdata_out(dmem_rdata_in),
		.dmem_wdata_in(dmem_wdata_out), .dmem_we_in(dmem_we_out));
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic put(input logic [14:0] w);
		i_core_mem_model.pmem[pc] = w;
		pc++;
	endtask
	// expectation: next fetch address, working register, flags z c half wrap
	task automatic note;
		done_q.push_back({pc, acc, fl});
	endtask
	function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		return {s[7:0] == 8'h00, s[8], h[4], a[7] == b[7] && s[7] != a[7], s[7:0]};
	endfunction
	task automatic op(input core_pkg::op_type o, input logic [7:0] x);
		logic [7:0] m;
		logic [11:0] r;
		logic [8:0] t;
		logic tm;
		m = dm[x];
		tm = 1'b0;
		case (o)
			core_pkg::OP_ADD_IMM: r = alu(acc, x, 1'b0);
			core_pkg::OP_SUB_IMM: r = alu(acc, ~x, 1'b1);
			core_pkg::OP_ADDC_MEM: r = alu(acc, m, fl[2]);
			core_pkg::OP_ADD_TO_MEM: {tm, r} = {1'b1, alu(acc, m, 1'b0)};
			core_pkg::OP_SUB_MEM: r = alu(acc, ~m, 1'b1);
			core_pkg::OP_SUBC_TO_MEM: {tm, r} = {1'b1, alu(acc, ~m, fl[2])};
			core_pkg::OP_AND_IMM: r = {(acc & x) == 8'h00, fl[2:0], acc & x};
			core_pkg::OP_OR_MEM: r = {(acc | m) == 8'h00, fl[2:0], acc | m};
			core_pkg::OP_XOR_TO_MEM: {tm, r} = {1'b1, (acc ^ m) == 8'h00, fl[2:0], acc ^ m};
			core_pkg::OP_INVERT: r = {m == 8'hFF, fl[2:0], ~m};
			core_pkg::OP_INC_TO_MEM: {tm, r} = {1'b1, m == 8'hFF, fl[2:0], m + 8'h01};
			core_pkg::OP_DEC: r = {m == 8'h01, fl[2:0], m - 8'h01};
			core_pkg::OP_LOAD_MEM: r = {fl, m};
			core_pkg::OP_LOAD_IMM: r = {fl, x};
			core_pkg::OP_STORE_MEM: {tm, r} = {1'b1, fl, acc};
			core_pkg::OP_ROR: r = {fl, m[0], m[7:1]};
			core_pkg::OP_ROL_TO_MEM: {tm, r} = {1'b1, fl, m[6:0], m[7]};
			// through-carry forms: outgoing bit lands in carry, old carry fills the gap
			core_pkg::OP_ROR_THRU: r = {fl[3], m[0], fl[1:0], fl[2], m[7:1]};
			core_pkg::OP_ROL_THRU_TO_MEM: {tm, r} = {1'b1, fl[3], m[7], fl[1:0], m[6:0], fl[2]};
			default: begin
				t = {1'b0, acc} + ((acc[3:0] > 4'h9 || fl[1]) ? 9'h006 : 9'h000);
				t = t + ((t[7:4] > 4'h9 || fl[2] || t[8]) ? 9'h060 : 9'h000);
				{tm, r} = {1'b1, fl[3], fl[2] | t[8], fl[1:0], t[7:0]};
			end
		endcase
		fl = r[11:8];
		if (tm) begin
			dm[x] = r[7:0];
			wr_q.push_back({x, r[7:0]});
		end else
			acc = r[7:0];
		put({1'b0, 6'(o), x});
		note;
	endtask
	always @(negedge clk_in) begin
		if (nrst_in === 1'b1 && instr_done_out === 1'b1 && done_q.size() > 0) begin
			@(negedge clk_in);
			nx = done_q.pop_front();
			chk({pmem_addr_out, working_register_out, zero_flag_out, carry_flag_out,
				half_nibble_flag_out, signed_wrap_flag_out}, nx);
			chk({12'h000, program_pointer_out}, {12'h000, nx[23:12]});
		end
	end
	always @(negedge clk_in) begin
		if (nrst_in === 1'b1 && dmem_we_out === 1'b1)
			chk({8'h00, dmem_addr_out, dmem_wdata_out},
				wr_q.size() ? {8'h00, wr_q.pop_front()} : 24'hXXXXXX);
	end
	initial begin
		#50000;
		err_total++;
		test_done;
	end
	initial begin
		pc = 12'h000;
		acc = 8'h00;
		fl = 4'h0;
		for (int i = 0; i < 4096; i++)
			i_core_mem_model.pmem[i] = 15'h0000;
		for (int i = 0; i < 256; i++) begin
			dm[i] = (i == 96) ? 8'h00 : 8'($random(seed));
			i_core_mem_model.dmem[i] = dm[i];
		end
		for (int i = 0; i < 8; i++)
			op(i[0] ? core_pkg::OP_SUB_IMM : core_pkg::OP_ADD_IMM, 8'($random(seed)));
		for (int i = 0; i < 34; i++)
			op(ops[i % 17], 8'h10 + 8'(i));
		op(core_pkg::OP_LOAD_IMM, 8'h38);
		op(core_pkg::OP_ADD_IMM, 8'h45);
		op(core_pkg::OP_BCD_FIXUP, 8'h30);
		op(core_pkg::OP_ADD_IMM, 8'h92);
		op(core_pkg::OP_BCD_FIXUP, 8'h31);
		for (int i = 0; i < 8; i++) begin
			put({i[0] ? core_pkg::PFX_BIT_CLEAR : core_pkg::PFX_BIT_SET, 3'(i), 8'h40});
			dm[8'h40] = i[0] ? dm[8'h40] & ~(8'h01 << i) : dm[8'h40] | (8'h01 << i);
			wr_q.push_back({8'h40, dm[8'h40]});
			note;
		end
		// bit tests on bits 0 and 1 of the byte just built: two skip, two fall through
		for (int i = 0; i < 4; i++) begin
			put({i[0] ? core_pkg::PFX_SKIP_BIT_ZERO : core_pkg::PFX_SKIP_BIT_SET, 3'(i / 2),
				8'h40});
			if (dm[8'h40][i / 2] != i[0])
				pc++;
			note;
		end
		put({core_pkg::PFX_GOTO, 12'h200});
		pc = 12'h200;
		note;
		ret = pc + 12'h001;
		put({core_pkg::PFX_CALL, 12'h300});
		pc = 12'h300;
		note;
		op(core_pkg::OP_ADD_IMM, 8'($random(seed)));
		put({1'b0, 6'(core_pkg::OP_LEAVE), 8'h00});
		pc = ret;
		note;
		// 0x60 stays zero: the arithmetic sweep above never writes there
		for (int i = 96; i < 98; i++) begin
			put({1'b0, 6'(core_pkg::OP_SKIP_ZERO), 8'(i)});
			if (dm[i] == 8'h00)
				pc++;
			note;
		end
		op(core_pkg::OP_LOAD_IMM, 8'hC0);
		put({1'b0, 6'(core_pkg::OP_STORE_MEM), 8'h06});
		pc = {pc[11:8], acc};
		note;
		op(core_pkg::OP_LOAD_IMM, 8'hE0);
		tw = 15'($random(seed));
		i_core_mem_model.pmem[{pc[11:8], 8'hE0}] = tw;
		put({1'b0, 6'(core_pkg::OP_TABLE_READ), 8'h50});
		wr_q.push_back({8'h50, tw[7:0]});
		note;
		repeat (3) @(negedge clk_in);
		nrst_in = 1'b1;
		for (int i = 0; i < 3000 && done_q.size() + wr_q.size() > 0; i++)
			@(negedge clk_in);
		repeat (8) @(negedge clk_in);
		chk(24'(done_q.size() + wr_q.size()), 24'h000000);
		chk({17'h00000, table_high_out}, {17'h00000, tw[14:8]});
		test_done;
	end
endmodule
